// File: inc/eac_regs.vh
// constants of the serial memory client: control byte fields, widths, write timer
// assumes inclusion by bare name from the design files under verilog/
`ifndef EAC_REGS_VH
`define EAC_REGS_VH

// ==========================================================
// control byte layout
`define EAC_DEV_TYPE        4'hA
`define EAC_TYPE_MSB        7
`define EAC_TYPE_LSB        4
`define EAC_SEL_MSB         3
`define EAC_SEL_LSB         1
`define EAC_RW_BIT          0

// ==========================================================
// array and buffer shape
`define EAC_ADDR_W          8
`define EAC_DATA_W          8
`define EAC_FIFO_DEPTH      4
`define EAC_FIFO_AW         2
`define EAC_PTR_RST         8'h00
`define EAC_PTR_STEP        8'h01

// ==========================================================
// bit counter values
`define EAC_BITS_PER_BYTE   4'h8
`define EAC_CNT_RST         4'h0
`define EAC_CNT_ONE         4'h1

// ==========================================================
// write cycle timing
`define EAC_CLK_MHZ         50
`define EAC_WRITE_TIME_US   5000
`define EAC_WRITE_CYCLES    (`EAC_WRITE_TIME_US * `EAC_CLK_MHZ)
`define EAC_TMR_W           24

`endif

// File: verilog/eac_fifo.v
// small first-in first-out buffer with valid/ready on both sides and a flush
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module eac_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,
    input  wire             srst,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW:0]      wr_ptr_ff;
    reg [AW:0]      rd_ptr_ff;

    wire full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    wire empty = (wr_ptr_ff == rd_ptr_ff);
    wire push  = in_valid & ~full;
    wire pop   = out_ready & ~empty;

    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = store[rd_ptr_ff[AW-1:0]];

    always @(posedge clk) begin
        if (push) begin
            store[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (srst || flush) begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule

// File: verilog/eac_mem.v
// byte array with one write port and one asynchronous read port
// assumes one clock; contents start at zero and are never reset
`timescale 1ns/1ps

module eac_mem #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clk,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire [AW-1:0] rd_addr,
    output wire [DW-1:0] rd_data
);

    reg [DW-1:0] cells [0:(1<<AW)-1];
    integer      i;

    initial begin
        for (i = 0; i < (1<<AW); i = i + 1) begin
            cells[i] = {DW{1'b0}};
        end
    end

    always @(posedge clk) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
    end

    assign rd_data = cells[rd_addr];

endmodule

// File: verilog/eac_top.v
// two-wire bus client of a small byte memory: reads, pointer, write cycle and busy polling
// assumes SCL and SDA arrive asynchronously and the bus host keeps its own protocol
//
// Notes on behaviour
// RULE1: control bytes addressed here are not acknowledged while the write cycle runs.
// RULE2: the timed write cycle starts at the Stop ending a write, never earlier.
// RULE3: host polls after Stop with Start and control byte, read/write bit zero.
// RULE4: control byte is acknowledged once the cycle ends; host then continues.
// RULE5: a read starts like a write but with read/write bit one.
// RULE6: pointer holds last accessed location plus one for current-address reads.
// RULE7: read control byte is acknowledged, then one 8-bit word is driven out.
// RULE8: host not-acknowledge then Stop ends the read; the data line is released.
// RULE9: word address inside a write loads the pointer before repeated Start aborts.
// RULE10: after repeated Start, read control byte returns the byte at loaded address.
// RULE11: each host acknowledge during a read sends the next sequential byte.
// RULE12: pointer steps by one after every byte read or written.
// RULE13: host software may use the three select bits as upper address bits.
// RULE14: the pointer never carries into the select bits; reads stay in one device.
// RULE15: array writes are blocked while the supply detector reports low supply.
// RULE16: memory commands answered only when the type field equals 1010.
// RULE17: control bits 3 to 1 must equal the three device select pins.
// RULE18: a counter times the write cycle; busy holds from Stop until it expires.
// RULE19: the 8-bit pointer wraps from the last location back to zero.
`timescale 1ns/1ps
`include "eac_regs.vh"

module eac_top #(
    parameter WRITE_CYCLES = `EAC_WRITE_CYCLES,
    parameter FIFO_DEPTH   = `EAC_FIFO_DEPTH,
    parameter FIFO_AW      = `EAC_FIFO_AW
) (
    input  wire       CORE_CLK,
    input  wire       SRST,
    input  wire       SCL_I,
    input  wire       SDA_I,
    output wire       SDA_O,
    output wire       SDA_OE_N,
    input  wire [2:0] DEVICE_SELECT_PINS,
    input  wire       SUPPLY_LOW,
    output wire       WRITE_BUSY
);

    // ==========================================================
    // local codes
    localparam ST_IDLE = 5'b00001;
    localparam ST_RX   = 5'b00010;
    localparam ST_ACK  = 5'b00100;
    localparam ST_TX   = 5'b01000;
    localparam ST_RACK = 5'b10000;

    localparam KD_CTRL  = 2'h0;
    localparam KD_WADDR = 2'h1;
    localparam KD_WDATA = 2'h2;

    localparam AW = `EAC_ADDR_W;
    localparam DW = `EAC_DATA_W;
    localparam FW = AW + DW;

    localparam integer          TMR_LOAD_I = WRITE_CYCLES - 1;
    localparam [`EAC_TMR_W-1:0] TMR_LOAD = TMR_LOAD_I[`EAC_TMR_W-1:0];
    localparam [`EAC_TMR_W-1:0] TMR_ZERO = 24'h00_0000;
    localparam [`EAC_TMR_W-1:0] TMR_STEP = 24'h00_0001;

    // ==========================================================
    // functions
    function ctrl_match;
        input [7:0] ctrl;
        input [2:0] sel;
        begin
            ctrl_match = (ctrl[`EAC_TYPE_MSB:`EAC_TYPE_LSB] == `EAC_DEV_TYPE) &&
                         (ctrl[`EAC_SEL_MSB:`EAC_SEL_LSB] == sel);
        end
    endfunction

    // pointer is exactly AW bits wide, so the step wraps to zero [RULE19]
    function [AW-1:0] ptr_inc;
        input [AW-1:0] ptr;
        begin
            ptr_inc = ptr + `EAC_PTR_STEP;
        end
    endfunction

    // ==========================================================
    // input synchronisers
    reg       scl_s1_ff;
    reg       scl_s2_ff;
    reg       scl_s3_ff;
    reg       sda_s1_ff;
    reg       sda_s2_ff;
    reg       sda_s3_ff;
    reg [2:0] sel_s1_ff;
    reg [2:0] sel_s2_ff;
    reg       low_s1_ff;
    reg       low_s2_ff;

    always @(posedge CORE_CLK) begin
        if (SRST) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_s3_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_s3_ff <= 1'b1;
            sel_s1_ff <= 3'h0;
            sel_s2_ff <= 3'h0;
            low_s1_ff <= 1'b1;
            low_s2_ff <= 1'b1;
        end else begin
            scl_s1_ff <= SCL_I;
            scl_s2_ff <= scl_s1_ff;
            scl_s3_ff <= scl_s2_ff;
            sda_s1_ff <= SDA_I;
            sda_s2_ff <= sda_s1_ff;
            sda_s3_ff <= sda_s2_ff;
            sel_s1_ff <= DEVICE_SELECT_PINS;
            sel_s2_ff <= sel_s1_ff;
            low_s1_ff <= SUPPLY_LOW;
            low_s2_ff <= low_s1_ff;
        end
    end

    wire scl_rise  = scl_s2_ff & ~scl_s3_ff;
    wire scl_fall  = ~scl_s2_ff & scl_s3_ff;
    wire start_det = scl_s2_ff & scl_s3_ff & ~sda_s2_ff & sda_s3_ff;
    wire stop_det  = scl_s2_ff & scl_s3_ff & sda_s2_ff & ~sda_s3_ff;

    // ==========================================================
    // state
    reg [4:0]    state_ff;
    reg [1:0]    kind_ff;
    reg [7:0]    shreg_ff;
    reg [3:0]    cnt_ff;
    reg          oe_n_ff;
    reg [AW-1:0] ptr_ff;
    reg          rw_ff;
    reg          ack_ff;
    reg          push_ff;
    reg [FW-1:0] push_data_ff;
    reg          pend_ff;
    reg          go_ff;
    reg          flush_ff;
    reg          busy_ff;
    reg [`EAC_TMR_W-1:0] tmr_ff;

    reg [4:0]    nxt_state;
    reg [1:0]    nxt_kind;
    reg [7:0]    nxt_shreg;
    reg [3:0]    nxt_cnt;
    reg          nxt_oe_n;
    reg [AW-1:0] nxt_ptr;
    reg          nxt_rw;
    reg          nxt_ack;
    reg          nxt_push;
    reg [FW-1:0] nxt_push_data;
    reg          nxt_pend;
    reg          nxt_go;
    reg          nxt_flush;

    wire          fifo_in_ready;
    wire          fifo_out_valid;
    wire [FW-1:0] fifo_out_data;
    wire [DW-1:0] mem_rd_data;

    // ==========================================================
    // acknowledge decision for the byte just received
    wire ctrl_hit = ctrl_match(shreg_ff, sel_s2_ff) & ~busy_ff; // [RULE1] [RULE16] [RULE17] [RULE4]
    reg  rx_ack;

    always @* begin
        rx_ack = 1'b0;
        case (kind_ff)
            KD_CTRL: begin
                rx_ack = ctrl_hit;
            end
            KD_WADDR: begin
                rx_ack = 1'b1;
            end
            KD_WDATA: begin
                rx_ack = fifo_in_ready;
            end
            default: begin
                rx_ack = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // bus protocol engine
    always @* begin
        nxt_state     = state_ff;
        nxt_kind      = kind_ff;
        nxt_shreg     = shreg_ff;
        nxt_cnt       = cnt_ff;
        nxt_oe_n      = oe_n_ff;
        nxt_ptr       = ptr_ff;
        nxt_rw        = rw_ff;
        nxt_ack       = ack_ff;
        nxt_push      = 1'b0;
        nxt_push_data = push_data_ff;
        nxt_pend      = pend_ff;
        nxt_go        = 1'b0;
        nxt_flush     = 1'b0;
        if (stop_det) begin
            nxt_state = ST_IDLE;
            nxt_oe_n  = 1'b1; // [RULE8]
            if (pend_ff) begin
                nxt_go   = 1'b1; // [RULE2]
                nxt_pend = 1'b0;
            end
        end else if (start_det) begin
            nxt_state = ST_RX;
            nxt_kind  = KD_CTRL;
            nxt_cnt   = `EAC_CNT_RST;
            nxt_oe_n  = 1'b1;
            if (pend_ff) begin
                // write abandoned without Stop: its bytes are dropped [RULE2]
                nxt_flush = 1'b1;
                nxt_pend  = 1'b0;
            end
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_oe_n = 1'b1;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        nxt_shreg = {shreg_ff[6:0], sda_s2_ff};
                        nxt_cnt   = cnt_ff + `EAC_CNT_ONE;
                    end else if (scl_fall && (cnt_ff == `EAC_BITS_PER_BYTE)) begin
                        nxt_ack   = rx_ack;
                        nxt_oe_n  = ~rx_ack;
                        nxt_state = ST_ACK;
                        if (kind_ff == KD_CTRL) begin
                            nxt_rw = shreg_ff[`EAC_RW_BIT]; // [RULE5]
                        end
                        if (kind_ff == KD_WADDR) begin
                            nxt_ptr = shreg_ff; // [RULE9]
                        end
                        if ((kind_ff == KD_WDATA) && rx_ack) begin
                            nxt_push      = 1'b1;
                            nxt_push_data = {ptr_ff, shreg_ff};
                            nxt_ptr       = ptr_inc(ptr_ff); // [RULE12] [RULE6]
                            nxt_pend      = 1'b1;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        nxt_oe_n = 1'b1;
                        if (!ack_ff) begin
                            nxt_state = ST_IDLE;
                        end else if ((kind_ff == KD_CTRL) && rw_ff) begin
                            // first bit of the byte at the pointer goes out now [RULE7] [RULE10] [RULE6]
                            nxt_oe_n  = mem_rd_data[7];
                            nxt_shreg = {mem_rd_data[6:0], 1'b0};
                            nxt_ptr   = ptr_inc(ptr_ff); // [RULE12] [RULE14]
                            nxt_cnt   = `EAC_CNT_ONE;
                            nxt_state = ST_TX;
                        end else begin
                            nxt_cnt   = `EAC_CNT_RST;
                            nxt_state = ST_RX;
                            nxt_kind  = (kind_ff == KD_CTRL) ? KD_WADDR : KD_WDATA;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_ff == `EAC_BITS_PER_BYTE) begin
                            nxt_oe_n  = 1'b1;
                            nxt_state = ST_RACK;
                        end else begin
                            nxt_oe_n  = shreg_ff[7];
                            nxt_shreg = {shreg_ff[6:0], 1'b0};
                            nxt_cnt   = cnt_ff + `EAC_CNT_ONE;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        if (!sda_s2_ff) begin
                            // host acknowledge: reuse the load path for the next byte [RULE11]
                            nxt_ack   = 1'b1;
                            nxt_state = ST_ACK;
                        end else begin
                            nxt_state = ST_IDLE; // [RULE8]
                        end
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_oe_n  = 1'b1;
                end
            endcase
        end
    end

    always @(posedge CORE_CLK) begin
        if (SRST) begin
            state_ff     <= ST_IDLE;
            kind_ff      <= KD_CTRL;
            shreg_ff     <= 8'h00;
            cnt_ff       <= `EAC_CNT_RST;
            oe_n_ff      <= 1'b1;
            ptr_ff       <= `EAC_PTR_RST;
            rw_ff        <= 1'b0;
            ack_ff       <= 1'b0;
            push_ff      <= 1'b0;
            push_data_ff <= 16'h0000;
            pend_ff      <= 1'b0;
            go_ff        <= 1'b0;
            flush_ff     <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            kind_ff      <= nxt_kind;
            shreg_ff     <= nxt_shreg;
            cnt_ff       <= nxt_cnt;
            oe_n_ff      <= nxt_oe_n;
            ptr_ff       <= nxt_ptr;
            rw_ff        <= nxt_rw;
            ack_ff       <= nxt_ack;
            push_ff      <= nxt_push;
            push_data_ff <= nxt_push_data;
            pend_ff      <= nxt_pend;
            go_ff        <= nxt_go;
            flush_ff     <= nxt_flush;
        end
    end

    // ==========================================================
    // write cycle timer and busy flag
    wire tmr_done = (tmr_ff == TMR_ZERO);

    always @(posedge CORE_CLK) begin
        if (SRST) begin
            busy_ff <= 1'b0;
            tmr_ff  <= TMR_ZERO;
        end else if (go_ff) begin
            busy_ff <= 1'b1; // [RULE18] [RULE2]
            tmr_ff  <= TMR_LOAD;
        end else if (busy_ff) begin
            if (!tmr_done) begin
                tmr_ff <= tmr_ff - TMR_STEP;
            end else if (!fifo_out_valid) begin
                busy_ff <= 1'b0; // [RULE18]
            end
        end
    end

    // ==========================================================
    // write buffer, drained into the array only during the write cycle
    wire drain_ready = busy_ff;
    wire mem_wr_en   = fifo_out_valid & drain_ready & ~low_s2_ff; // [RULE15]

    eac_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (CORE_CLK),
        .srst      (SRST),
        .flush     (flush_ff),
        .in_valid  (push_ff),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_ff),
        .out_valid (fifo_out_valid),
        .out_ready (drain_ready),
        .out_data  (fifo_out_data)
    );

    eac_mem #(
        .AW (AW),
        .DW (DW)
    ) u_mem (
        .clk     (CORE_CLK),
        .wr_en   (mem_wr_en),
        .wr_addr (fifo_out_data[FW-1:DW]),
        .wr_data (fifo_out_data[DW-1:0]),
        .rd_addr (ptr_ff),
        .rd_data (mem_rd_data)
    );

    // ==========================================================
    // outputs
    assign SDA_O      = 1'b0;
    assign SDA_OE_N   = oe_n_ff;
    assign WRITE_BUSY = busy_ff;

endmodule

// File: verilog/eac_top_unused_guard.v
// spare design file: holds no logic of its own
// assumes the block's modules are eac_top, eac_fifo and eac_mem

// File: bench/eac_top_props.sv
// checker of the memory client pins: write cycle, busy polling, acknowledge timing
// assumes bind to eac_top; watches only its ports
`timescale 1ns/1ps
`include "eac_regs.vh"

module eac_top_props #(
    parameter int WRITE_CYCLES = 20,
    parameter int FIFO_DEPTH   = 4,
    parameter int FIFO_AW      = 2
) (
    input wire logic       CORE_CLK,
    input wire logic       SRST,
    input wire logic       SCL_I,
    input wire logic       SDA_I,
    input wire logic       SDA_O,
    input wire logic       SDA_OE_N,
    input wire logic [2:0] DEVICE_SELECT_PINS,
    input wire logic       SUPPLY_LOW,
    input wire logic       WRITE_BUSY
);
    // ==========================================================
    // bus event tracking
    logic        scl_ff, sda_ff, first_ff;
    logic [7:0]  since_stop_ff, since_fall_ff, free_ff, sh_ff;
    logic [23:0] busy_cnt_ff;
    logic [3:0]  bit_cnt_ff;
    wire start_ev = scl_ff & SCL_I & sda_ff & ~SDA_I;
    wire stop_ev  = scl_ff & SCL_I & ~sda_ff & SDA_I;
    wire ack_slot = first_ff & (bit_cnt_ff == 4'h9) & scl_ff & SCL_I;
    wire match    = (sh_ff[7:4] == `EAC_DEV_TYPE) & (sh_ff[3:1] == DEVICE_SELECT_PINS);

    always @(posedge CORE_CLK) begin
        scl_ff        <= SCL_I;
        sda_ff        <= SDA_I;
        since_stop_ff <= stop_ev ? 8'h00 : since_stop_ff + 8'(since_stop_ff != 8'hFF);
        since_fall_ff <= (scl_ff & ~SCL_I) ? 8'h00 : since_fall_ff + 8'(since_fall_ff != 8'hFF);
        free_ff       <= WRITE_BUSY ? 8'h00 : free_ff + 8'(free_ff != 8'hFF);
        busy_cnt_ff   <= WRITE_BUSY ? busy_cnt_ff + 24'h00_0001 : 24'h00_0000;
        if (start_ev) begin
            bit_cnt_ff <= 4'h0;
            first_ff   <= 1'b1;
        end else if (stop_ev) begin
            first_ff <= 1'b0;
        end else if (~scl_ff & SCL_I) begin
            if (bit_cnt_ff < 4'h8) sh_ff <= {sh_ff[6:0], SDA_I};
            if (bit_cnt_ff == 4'h9) begin
                bit_cnt_ff <= 4'h1;
                first_ff   <= 1'b0;
            end else begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
        end
        if (SRST) begin
            since_stop_ff <= 8'hFF;
            since_fall_ff <= 8'hFF;
            free_ff       <= 8'h00;
            busy_cnt_ff   <= 24'h00_0000;
            first_ff      <= 1'b0;
            bit_cnt_ff    <= 4'h0;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    // ==========================================================
    // assertions
    AST_RST_RELEASE: assert property ($past(SRST) |-> SDA_OE_N && !WRITE_BUSY)
        else $error("outputs not idle after reset");
    AST_OPEN_DRAIN: assert property (SDA_O == 1'b0)
        else $error("data line driven high");
    AST_BUSY_AFTER_STOP: assert property ($rose(WRITE_BUSY) |-> since_stop_ff <= 8'd12)
        else $error("write cycle began without a stop");
    AST_BUSY_SILENT: assert property (WRITE_BUSY |-> SDA_OE_N)
        else $error("data line pulled during write cycle");
    AST_BUSY_MIN: assert property ($fell(WRITE_BUSY) |-> busy_cnt_ff >= WRITE_CYCLES)
        else $error("write cycle too short");
    AST_BUSY_MAX: assert property (busy_cnt_ff <= WRITE_CYCLES + 40)
        else $error("write cycle too long");
    AST_OE_AFTER_FALL: assert property ($changed(SDA_OE_N) |-> since_fall_ff <= 8'd8)
        else $error("data line changed away from clock fall");
    AST_NACK_FOREIGN: assert property (ack_slot && !SDA_OE_N |-> match && !WRITE_BUSY)
        else $error("foreign or busy control byte acknowledged");
    AST_ACK_MATCH: assert property (ack_slot && match && free_ff == 8'hFF |-> !SDA_OE_N)
        else $error("own control byte not acknowledged");

    cover property ($fell(WRITE_BUSY));
    cover property (ack_slot && SDA_OE_N);
    cover property (!first_ff && bit_cnt_ff == 4'h9 && SCL_I && !SDA_OE_N);
endmodule

bind eac_top eac_top_props #(.WRITE_CYCLES(WRITE_CYCLES), .FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) u_props (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N),
    .DEVICE_SELECT_PINS(DEVICE_SELECT_PINS), .SUPPLY_LOW(SUPPLY_LOW), .WRITE_BUSY(WRITE_BUSY));

// File: bench/eac_host.sv
// bus host model: start, stop, byte write and byte read on the two-wire bus
// assumes a pull-up on the data wire; the wire level returns on sda_in
`timescale 1ns/1ps

module eac_host (
    input  wire logic clk,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one clock period; value 1 releases the line
    task automatic bit_x(input logic b, output logic r);
        sda <= b;
        tick(5);
        scl <= 1'b1;
        tick(5);
        r = sda_in;
        tick(5);
        scl <= 1'b0;
        tick(5);
    endtask

    task automatic bus_start();
        sda <= 1'b1;
        tick(5);
        scl <= 1'b1;
        tick(5);
        sda <= 1'b0;
        tick(5);
        scl <= 1'b0;
        tick(5);
    endtask

    task automatic bus_stop();
        sda <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(5);
        sda <= 1'b1;
        tick(10);
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = (r === 1'b0);
    endtask

    task automatic rbyte(input logic host_ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            b[i] = r;
        end
        bit_x(!host_ack, r);
    endtask
endmodule

// File: bench/eac_top_tb.sv
// self-checking bench of the memory client: writes, polling, reads, select and type decode
// assumes eac_host as bus host and the bound checker
`timescale 1ns/1ps
`include "eac_regs.vh"

module eac_top_tb;
    localparam int WC = 600;
    logic       CORE_CLK, SRST, SUPPLY_LOW;
    logic [2:0] DEVICE_SELECT_PINS;
    wire        scl, sda_h, sda_o, sda_oe_n, busy;
    wire        sda_w = sda_h & (sda_oe_n | sda_o);
    int         n_fail, n_compared;
    logic [7:0] mem [256];
    logic [7:0] ptr;

    eac_top #(.WRITE_CYCLES(WC)) u_dut (
        .CORE_CLK(CORE_CLK), .SRST(SRST), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
        .DEVICE_SELECT_PINS(DEVICE_SELECT_PINS), .SUPPLY_LOW(SUPPLY_LOW), .WRITE_BUSY(busy));
    eac_host u_host (.clk(CORE_CLK), .sda_in(sda_w), .scl(scl), .sda(sda_h));

    initial begin
        CORE_CLK = 1'b0;
        forever #10 CORE_CLK = ~CORE_CLK;
    end

    // ==========================================================
    // helpers
    function automatic logic [7:0] ctl(input logic rw);
        return {`EAC_DEV_TYPE, DEVICE_SELECT_PINS, rw};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (n_fail == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic do_write(input logic [7:0] a, input int n);
        logic       ack;
        logic [7:0] d;
        int         k;
        u_host.bus_start();
        u_host.wbyte(ctl(1'b0), ack);
        check(ack, 8'h01);
        u_host.wbyte(a, ack);
        check(ack, 8'h01);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            u_host.wbyte(d, ack);
            check(ack, 8'(i < 4));
            if (i < 4 && !SUPPLY_LOW) mem[a + 8'(i)] = d;
        end
        check(busy, 8'h00);
        u_host.bus_stop();
        check(busy, 8'h01);
        ptr = a + 8'(n < 4 ? n : 4);
        k = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && k < 40) begin
            u_host.bus_start();
            u_host.wbyte(ctl(1'b0), ack);
            u_host.bus_stop();
            k++;
        end
        check(8'(k > 1), 8'h01);
        check(busy, 8'h00);
        if (k == 40) begin
            n_fail++;
            end_of_test();
        end
    endtask

    task automatic do_read(input logic rnd, input logic [7:0] a, input int n);
        logic       ack;
        logic [7:0] d;
        if (rnd) begin
            u_host.bus_start();
            u_host.wbyte(ctl(1'b0), ack);
            u_host.wbyte(a, ack);
            ptr = a;
        end
        u_host.bus_start();
        u_host.wbyte(ctl(1'b1), ack);
        check(ack, 8'h01);
        for (int i = 0; i < n; i++) begin
            u_host.rbyte(i < n - 1, d);
            check(d, mem[ptr]);
            ptr = ptr + 8'h01;
        end
        u_host.bus_stop();
        check(sda_oe_n, 8'h01);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic       ack;
        logic [7:0] a, d;
        n_fail = 0;
        n_compared = 0;
        SRST = 1'b1;
        SUPPLY_LOW = 1'b0;
        ptr = 8'h00;
        foreach (mem[i]) mem[i] = 8'h00;
        void'($urandom(32'h47dd));
        DEVICE_SELECT_PINS = 3'($urandom);
        repeat (16) @(posedge CORE_CLK);
        check(sda_oe_n, 8'h01);
        check(busy, 8'h00);
        SRST <= 1'b0;
        repeat (8) @(posedge CORE_CLK);
        do_write(8'hFE, 3);
        do_read(1'b1, 8'hFF, 2);
        do_read(1'b0, 8'h00, 1);
        for (int j = 0; j < 6; j++) begin
            a = 8'($urandom);
            do_write(a, 1 + ($urandom % 4));
            do_read(1'b1, a, 4);
            do_read(1'b0, 8'h00, 1);
        end
        a = 8'($urandom);
        do_write(a, 5);
        do_read(1'b0, 8'h00, 2);
        do_read(1'b1, a, 4);
        SUPPLY_LOW <= 1'b1;
        do_write(a, 2);
        SUPPLY_LOW <= 1'b0;
        do_read(1'b1, a, 2);
        for (int s = 0; s < 8; s++) begin
            u_host.bus_start();
            u_host.wbyte({`EAC_DEV_TYPE, 3'(s), 1'b1}, ack);
            check(ack, 8'(3'(s) == DEVICE_SELECT_PINS));
            if (ack === 1'b1) begin
                u_host.rbyte(1'b0, d);
                check(d, mem[ptr]);
                ptr = ptr + 8'h01;
            end
            u_host.bus_stop();
        end
        for (int t = 0; t < 16; t++) begin
            u_host.bus_start();
            u_host.wbyte({4'(t), DEVICE_SELECT_PINS, 1'b0}, ack);
            check(ack, 8'(4'(t) == `EAC_DEV_TYPE));
            u_host.bus_stop();
        end
        SRST <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        SRST <= 1'b0;
        repeat (8) @(posedge CORE_CLK);
        ptr = 8'h00;
        do_read(1'b0, 8'h00, 1);
        end_of_test();
    end
endmodule
